/* msh_defines.vh */
// Purpose: constants for the slave-channel host controller
// Assumes: 32-bit classic wishbone, 100 MHz ref_clk_i
// Notes:   device register indices and field positions
`ifndef MSH_DEFINES_VH
`define MSH_DEFINES_VH

// own wishbone register byte offsets
`define MSH_WB_CTRL        8'h00
`define MSH_WB_STATUS      8'h04
`define MSH_WB_TXDATA      8'h08
`define MSH_WB_RXDATA      8'h0C
`define MSH_WB_FRAMES      8'h10
// control bits (write-one pulses)
`define MSH_CTRL_CONFIG    0
`define MSH_CTRL_START     1
// status bits
`define MSH_ST_CFG_DONE    0
`define MSH_ST_BUSY        1
`define MSH_ST_RX_NEW      2
`define MSH_ST_JOB_DONE    3

// device register indices on the config port, in write order
`define MSH_IDX_MODE       4'h0
`define MSH_IDX_CHECK      4'h1
`define MSH_IDX_ENABLES    4'h2
`define MSH_IDX_FORMAT     4'h3
`define MSH_IDX_FLEN       4'h4
`define MSH_IDX_CLKDIV     4'h5
`define MSH_IDX_TRIG       4'h6
`define MSH_IDX_SETUP      4'h7
`define MSH_IDX_HOLD       4'h8
`define MSH_IDX_IDLE       4'h9
`define MSH_IDX_INDA       4'hA
`define MSH_IDX_FCOUNT     4'hB
`define MSH_IDX_SSEL       4'hC
`define MSH_IDX_UNIT_EN    4'hD
`define MSH_CFG_LAST       4'hD

// device field positions
`define MSH_F_ROLE         0
`define MSH_F_SELECT_INPUT_ENABLE         1
`define MSH_F_TXE          0
`define MSH_F_RXE          1
`define MSH_F_PRIO_LSB     4
`define MSH_F_IRQ_LSB      12
`define MSH_F_PHASE        1
`define MSH_F_UNIT_EN      0

// device field values for slave use
`define MSH_V_PRIO_LOWEST  3'h7
`define MSH_V_IRQ_ALL      4'hF
`define MSH_V_CLKDIV       32'h0000_0001
`define MSH_V_DELAY_ONE    32'h0000_0001
`define MSH_V_DELAY_ZERO   32'h0000_0000
`define MSH_V_SSEL         32'h0000_0000

// link defaults
`define MSH_FRAME_BITS     32
`define MSH_FRAMES_RESET   8'h04
`define MSH_CLK_MHZ        100
`define MSH_SCK_NS         160
`define MSH_HALF_CYC       ((`MSH_SCK_NS * `MSH_CLK_MHZ) / 2000)

`endif

/* msh_host.v */
// Purpose: host for one slave spi channel: configures it, then masters frames
// Assumes: config port writes device registers by index; spi mode 1: clock idles low, phase 1
// Notes:   serial clock is made here by a divider, so no second clock domain
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`include "msh_defines.vh"

// Contract
// - sampling timing select written zero
// - output idle level select written 00
// - select polarity written all zeros
// - loopback enable written zero
// - channel priority written binary 111
// - channel hold written zero
// - polarity, idle, insertion, return written zero
// - safety protocol enable written zero
// - clock divide register written 0001
// - delays 0001, interdata 0000
// - buffer size written 00
// - chip-select selection written 0000
module msh_host #(
    parameter FRAME_BITS = `MSH_FRAME_BITS,
    parameter HALF_CYC   = `MSH_HALF_CYC
) (
    input  wire        ref_clk_i,
    input  wire        srst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [3:0]  cfg_idx_o,
    output reg  [31:0] cfg_data_o,
    output wire        cfg_wr_o,
    input  wire        cfg_ready_i,
    output reg         select_n_o,
    output reg         serial_clock_o,
    output reg         mosi_o,
    input  wire        miso_i
);

    localparam CFG_IDLE = 2'd0;
    localparam CFG_RUN  = 2'd1;
    localparam CFG_DONE = 2'd2;

    localparam SPI_IDLE = 2'd0;
    localparam SPI_RUN  = 2'd1;
    localparam SPI_TAIL = 2'd2;

    reg  [1:0]  cfg_state;
    reg  [3:0]  cfg_ptr;
    reg  [1:0]  spi_state;
    reg  [15:0] div_cnt;
    reg  [7:0]  bit_cnt;
    reg  [7:0]  frame_cnt;
    reg  [7:0]  frames;
    reg  [31:0] tx_data;
    reg  [31:0] rx_data;
    reg  [31:0] shift;
    reg         rx_new;
    reg         job_done;
    reg         miso_meta;
    reg         miso_s;
    wire        wb_hit;
    wire        wr_ctrl;
    wire        half_tick;

    // word for each device register, all slave-mode values
    function [31:0] cfg_word;
        input [3:0] idx;
        input [7:0] nfr;
        begin
            cfg_word = 32'h0000_0000;
            case (idx)
                `MSH_IDX_MODE: begin
                    // slave role, chip select recognised; rest zero
                    cfg_word[`MSH_F_ROLE] = 1'b1;
                    cfg_word[`MSH_F_SELECT_INPUT_ENABLE] = 1'b1;
                    // sample timing, idle level, polarity fields stay zero
                    cfg_word[15:2] = 14'h0000;
                end
                `MSH_IDX_CHECK: begin
                    cfg_word = 32'h0000_0000;
                end
                `MSH_IDX_ENABLES: begin
                    cfg_word[`MSH_F_TXE] = 1'b1;
                    cfg_word[`MSH_F_RXE] = 1'b1;
                    // direct memory mode, hold and continue off
                    cfg_word[`MSH_F_PRIO_LSB +: 3] = `MSH_V_PRIO_LOWEST;
                    cfg_word[7] = 1'b0;
                    cfg_word[8] = 1'b0;
                    cfg_word[`MSH_F_IRQ_LSB +: 4] = `MSH_V_IRQ_ALL;
                end
                `MSH_IDX_FORMAT: begin
                    // only phase set; order, parity, crc, safety at zero
                    cfg_word[`MSH_F_PHASE] = 1'b1;
                end
                `MSH_IDX_FLEN: begin
                    cfg_word = FRAME_BITS;
                end
                `MSH_IDX_CLKDIV: begin
                    cfg_word = `MSH_V_CLKDIV;
                end
                `MSH_IDX_TRIG: begin
                    cfg_word = 32'h0000_0000;
                end
                `MSH_IDX_SETUP: begin
                    cfg_word = `MSH_V_DELAY_ONE;
                end
                `MSH_IDX_HOLD: begin
                    cfg_word = `MSH_V_DELAY_ONE;
                end
                `MSH_IDX_IDLE: begin
                    cfg_word = `MSH_V_DELAY_ONE;
                end
                `MSH_IDX_INDA: begin
                    cfg_word = `MSH_V_DELAY_ZERO;
                end
                `MSH_IDX_FCOUNT: begin
                    cfg_word = {24'h00_0000, nfr};
                end
                `MSH_IDX_SSEL: begin
                    cfg_word = `MSH_V_SSEL;
                end
                `MSH_IDX_UNIT_EN: begin
                    cfg_word[`MSH_F_UNIT_EN] = 1'b1;
                end
                default: begin
                    cfg_word = 32'h0000_0000;
                end
            endcase
        end
    endfunction

    assign wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl   = wb_hit & wb_we_i & (wb_adr_i == `MSH_WB_CTRL) & wb_sel_i[0];
    assign half_tick = (div_cnt == HALF_CYC - 1);
    assign cfg_wr_o  = (cfg_state == CFG_RUN);

    // wishbone slave: ack one cycle after the strobe, dropped the next
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            tx_data  <= 32'h0000_0000;
            frames   <= `MSH_FRAMES_RESET;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit & wb_we_i) begin
                if (wb_adr_i == `MSH_WB_TXDATA) begin
                    tx_data <= wb_dat_i;
                end
                if ((wb_adr_i == `MSH_WB_FRAMES) & wb_sel_i[0]) begin
                    frames <= wb_dat_i[7:0];
                end
            end
            if (wb_hit & ~wb_we_i) begin
                case (wb_adr_i)
                    `MSH_WB_STATUS: begin
                        wb_dat_o <= {20'h0_0000, frame_cnt, job_done, rx_new,
                                     (spi_state != SPI_IDLE), (cfg_state == CFG_DONE)};
                    end
                    `MSH_WB_TXDATA: begin
                        wb_dat_o <= tx_data;
                    end
                    `MSH_WB_RXDATA: begin
                        wb_dat_o <= rx_data;
                    end
                    `MSH_WB_FRAMES: begin
                        wb_dat_o <= {24'h00_0000, frames};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000; // unmapped reads zero
                    end
                endcase
            end
        end
    end

    // config walk: one device register per accepted write, enable last
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_state  <= CFG_IDLE;
            cfg_ptr    <= 4'h0;
            cfg_idx_o  <= 4'h0;
            cfg_data_o <= 32'h0000_0000;
        end else begin
            case (cfg_state)
                CFG_IDLE: begin
                    if (wr_ctrl & wb_dat_i[`MSH_CTRL_CONFIG] & (spi_state == SPI_IDLE)) begin
                        cfg_state  <= CFG_RUN;
                        cfg_ptr    <= 4'h0;
                        cfg_idx_o  <= 4'h0;
                        cfg_data_o <= cfg_word(4'h0, frames);
                    end
                end
                CFG_RUN: begin
                    if (cfg_ready_i) begin
                        if (cfg_ptr == `MSH_CFG_LAST) begin
                            cfg_state <= CFG_DONE;
                        end else begin
                            cfg_ptr    <= cfg_ptr + 4'h1;
                            cfg_idx_o  <= cfg_ptr + 4'h1;
                            cfg_data_o <= cfg_word(cfg_ptr + 4'h1, frames);
                        end
                    end
                end
                CFG_DONE: begin
                    // a new config request rewrites everything
                    if (wr_ctrl & wb_dat_i[`MSH_CTRL_CONFIG] & (spi_state == SPI_IDLE)) begin
                        cfg_state  <= CFG_RUN;
                        cfg_ptr    <= 4'h0;
                        cfg_idx_o  <= 4'h0;
                        cfg_data_o <= cfg_word(4'h0, frames);
                    end
                end
                default: begin
                    cfg_state <= CFG_IDLE;
                end
            endcase
        end
    end

    // miso comes from the device pins: two flops before use
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            miso_meta <= 1'b0;
            miso_s    <= 1'b0;
        end else begin
            miso_meta <= miso_i;
            miso_s    <= miso_meta;
        end
    end

    // spi master; half period must exceed the 2-flop miso delay
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            spi_state      <= SPI_IDLE;
            div_cnt        <= 16'h0000;
            bit_cnt        <= 8'h00;
            frame_cnt      <= 8'h00;
            shift          <= 32'h0000_0000;
            rx_data        <= 32'h0000_0000;
            rx_new         <= 1'b0;
            job_done       <= 1'b0;
            select_n_o     <= 1'b1;
            serial_clock_o <= 1'b0;
            mosi_o         <= 1'b0;
        end else begin
            // reading rx data clears the flag; a new frame wins
            if (wb_hit & ~wb_we_i & (wb_adr_i == `MSH_WB_RXDATA)) begin
                rx_new <= 1'b0;
            end
            case (spi_state)
                SPI_IDLE: begin
                    div_cnt <= 16'h0000;
                    // software start only, after the config walk
                    if (wr_ctrl & wb_dat_i[`MSH_CTRL_START] & (cfg_state == CFG_DONE)
                        & (frames != 8'h00)) begin
                        spi_state  <= SPI_RUN;
                        select_n_o <= 1'b0;
                        shift      <= tx_data;
                        bit_cnt    <= 8'h00;
                        frame_cnt  <= 8'h00;
                        job_done   <= 1'b0;
                    end
                end
                SPI_RUN: begin
                    div_cnt <= half_tick ? 16'h0000 : div_cnt + 16'h0001;
                    if (half_tick) begin
                        serial_clock_o <= ~serial_clock_o;
                        if (!serial_clock_o) begin
                            // odd edge: drive the next bit, msb first
                            mosi_o <= shift[FRAME_BITS-1];
                        end else begin
                            // even edge: take the slave's bit
                            shift   <= {shift[FRAME_BITS-2:0], miso_s};
                            bit_cnt <= bit_cnt + 8'h01;
                            if (bit_cnt == FRAME_BITS - 1) begin
                                rx_data   <= {shift[FRAME_BITS-2:0], miso_s};
                                rx_new    <= 1'b1;
                                bit_cnt   <= 8'h00;
                                frame_cnt <= frame_cnt + 8'h01;
                                // reload here so the next frame follows at once
                                shift     <= tx_data;
                                if (frame_cnt + 8'h01 == frames) begin
                                    spi_state <= SPI_TAIL;
                                end
                            end
                        end
                    end
                end
                SPI_TAIL: begin
                    // hold select one half period past the last edge
                    div_cnt <= half_tick ? 16'h0000 : div_cnt + 16'h0001;
                    if (half_tick) begin
                        select_n_o <= 1'b1;
                        mosi_o     <= 1'b0;
                        job_done   <= 1'b1;
                        spi_state  <= SPI_IDLE;
                    end
                end
                default: begin
                    spi_state <= SPI_IDLE;
                end
            endcase
        end
    end

endmodule // msh_host

/* msh_host_assertions.sv */
// Purpose: port-level checks for the slave-channel host controller
// Assumes: HALF_CYC left at its default of 8 cycles
// Notes:   attached to every msh_host by the bind at the foot
module msh_host_assertions (
    input wire        ref_clk_i,
    input wire        srst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [3:0]  cfg_idx_o,
    input wire [31:0] cfg_data_o,
    input wire        cfg_wr_o,
    input wire        cfg_ready_i,
    input wire        select_n_o,
    input wire        serial_clock_o,
    input wire        mosi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // bus answers one cycle after the request, for one cycle only
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not in next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    // config walk: held while stalled, strict index order, enable last
    cfg_hold_a: assert property (cfg_wr_o && !cfg_ready_i |=> cfg_wr_o && $stable(cfg_idx_o) && $stable(cfg_data_o))
        else $error("config write changed while stalled");
    cfg_order_a: assert property (cfg_wr_o && cfg_ready_i && cfg_idx_o != 4'hD |=>
        cfg_wr_o && cfg_idx_o == $past(cfg_idx_o) + 4'h1) else $error("config index skipped");
    cfg_last_a: assert property (cfg_wr_o && cfg_ready_i && cfg_idx_o == 4'hD |=> !cfg_wr_o)
        else $error("config walk ran past unit enable");
    cfg_first_a: assert property ($rose(cfg_wr_o) |-> cfg_idx_o == 4'h0 && cfg_data_o == 32'h0000_0003)
        else $error("walk did not open with slave mode word");
    // serial clock only moves inside a frame, with fixed high phases and a fixed first low phase; data moves on rising edges
    sclk_idle_a: assert property (select_n_o |-> !serial_clock_o) else $error("clock moved while deselected");
    first_edge_a: assert property ($fell(select_n_o) |-> !serial_clock_o [*8] ##1 serial_clock_o)
        else $error("first clock edge mistimed");
    sclk_high_a: assert property ($rose(serial_clock_o) |-> serial_clock_o [*8] ##1 !serial_clock_o)
        else $error("clock high phase wrong length");
    mosi_edge_a: assert property (!select_n_o && !$past(select_n_o) && !$rose(serial_clock_o) |-> $stable(mosi_o))
        else $error("data changed off the rising edge");
endmodule // msh_host_assertions

bind msh_host msh_host_assertions u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cfg_idx_o(cfg_idx_o), .cfg_data_o(cfg_data_o), .cfg_wr_o(cfg_wr_o),
    .cfg_ready_i(cfg_ready_i), .select_n_o(select_n_o), .serial_clock_o(serial_clock_o), .mosi_o(mosi_o));

/* msh_dev_model.sv */
// Purpose: behavioural slave channel answering the host
// Assumes: clock idles low, data driven on rising and sampled on falling edges
// Notes:   ready can stall every other cycle; released data line toggles
module msh_dev_model (
    input  wire        ref_clk_i,
    input  wire        srst_i,
    input  wire        slow_i,
    input  wire [3:0]  cfg_idx_i,
    input  wire [31:0] cfg_data_i,
    input  wire        cfg_wr_i,
    output reg         cfg_ready_o,
    input  wire        select_n_i,
    input  wire        serial_clock_i,
    input  wire        mosi_i,
    output reg         miso_o,
    input  wire [31:0] dev_word_i
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [31:0] regs [0:13];
    reg [3:0]  next_idx;
    reg        order_err;
    reg        active;
    reg        sck_q;
    reg        sel_q;
    reg [5:0]  bit_cnt;
    reg [7:0]  frames;
    reg [31:0] shift;
    reg [31:0] rx_sr;
    reg [31:0] rx_word;
    integer    i;
    // register file and serial engine; no parity, crc or hardware trigger paths
    always @(posedge ref_clk_i) begin
        sck_q <= serial_clock_i;
        sel_q <= select_n_i;
        cfg_ready_o <= slow_i ? ~cfg_ready_o : 1'b1;
        if (srst_i) begin
            for (i = 0; i < 14; i = i + 1) regs[i] <= 32'h0000_0000;
            cfg_ready_o <= 1'b0;
            next_idx <= 4'h0;
            order_err <= 1'b0;
            active <= 1'b0;
            miso_o <= 1'b0;
            frames <= 8'h00;
        end else begin
            if (cfg_wr_i && cfg_ready_o) begin
                regs[cfg_idx_i] <= cfg_data_i;
                order_err <= order_err | (cfg_idx_i != next_idx);
                next_idx <= (cfg_idx_i == 4'hD) ? 4'h0 : cfg_idx_i + 4'h1;
                // channel armed only by the unit enable write, cleared after the last frame
                if (cfg_idx_i == 4'hD) active <= cfg_data_i[0] & regs[0][0] & regs[0][1];
            end
            if (select_n_i) begin
                miso_o <= ~miso_o; // line is released: never a stale bit
                bit_cnt <= 6'h00;
                shift <= dev_word_i;
            end else if (sel_q) begin
                frames <= 8'h00; // count kept after a job, restarted as select falls
            end else if (active === 1'b1) begin
                if (serial_clock_i && !sck_q) begin
                    miso_o <= shift[31];
                    shift <= {shift[30:0], 1'b0};
                end
                if (!serial_clock_i && sck_q) begin
                    rx_sr <= {rx_sr[30:0], mosi_i};
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h1F) begin
                        rx_word <= {rx_sr[30:0], mosi_i};
                        frames <= frames + 8'h01;
                        bit_cnt <= 6'h00;
                        shift <= dev_word_i;
                        if (frames + 8'h01 == regs[11][7:0]) active <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // msh_dev_model

/* tb.sv */
// Purpose: self-checking bench for the slave-channel host
// Assumes: default HALF_CYC, device model as far side
// Notes:   all waits bounded; a timeout counts as a mismatch
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    reg         ref_clk_i = 1'b0;
    reg         srst_i = 1'b1;
    reg         wb_cyc = 1'b0;
    reg         wb_stb = 1'b0;
    reg         wb_we = 1'b0;
    reg  [7:0]  wb_adr = 8'h00;
    reg  [31:0] wb_wdat = 32'h0000_0000;
    reg         slow = 1'b0;
    reg  [31:0] dev_word = 32'h0000_0000;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire [3:0]  cfg_idx;
    wire [31:0] cfg_data;
    wire        cfg_wr;
    wire        cfg_ready;
    wire        select_n;
    wire        sclk;
    wire        mosi;
    wire        miso;
    integer     fail_count = 0;
    integer     total_checks = 0;
    // fixed config words, index 13 down to 0; frame count slot patched per job
    localparam [447:0] CFG_EXP = {32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h20,
        32'h2, 32'hF073, 32'h0, 32'h3};

    always #5 ref_clk_i = ~ref_clk_i;

    msh_host #(.FRAME_BITS(32), .HALF_CYC(8)) dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_idx_o(cfg_idx), .cfg_data_o(cfg_data), .cfg_wr_o(cfg_wr),
        .cfg_ready_i(cfg_ready), .select_n_o(select_n), .serial_clock_o(sclk), .mosi_o(mosi), .miso_i(miso));
    msh_dev_model u_dev (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .slow_i(slow), .cfg_idx_i(cfg_idx),
        .cfg_data_i(cfg_data), .cfg_wr_i(cfg_wr), .cfg_ready_o(cfg_ready), .select_n_i(select_n),
        .serial_clock_i(sclk), .mosi_i(mosi), .miso_o(miso), .dev_word_i(dev_word));

    task automatic check(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb_cycle(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        integer n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        n = 0;
        @(posedge ref_clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge ref_clk_i);
        end
        if (n == 20) fail_count = fail_count + 1;
        if (n == 20) end_of_test;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        wb_cycle(a, 1'b1, d, q);
    endtask
    // poll status until the link is idle with the job marked done
    task automatic wait_done;
        reg [31:0] q;
        integer n;
        n = 0;
        q = 32'h0000_0002;
        while ((q[1] !== 1'b0 || q[3] !== 1'b1) && n < 2000) begin
            wb_cycle(8'h04, 1'b0, 32'h0, q);
            n = n + 1;
        end
        if (n == 2000) fail_count = fail_count + 1;
        if (n == 2000) end_of_test;
    endtask
    task automatic t_idle;
        reg [31:0] q;
        wb_cycle(8'h10, 1'b0, 32'h0, q);
        check(q, 32'h0000_0004);
        wr(8'h20, 32'hFFFF_FFFF);
        wb_cycle(8'h20, 1'b0, 32'h0, q);
        check(q, 32'h0000_0000);
        wr(8'h00, 32'h0000_0002);
        repeat (20) @(posedge ref_clk_i);
        check({31'h0, select_n}, 32'h0000_0001);
        wb_cycle(8'h04, 1'b0, 32'h0, q);
        check(q, 32'h0000_0000);
        $display("test idle done");
    endtask
    // config walk against the device model, with a stalling or prompt ready
    task automatic t_config(input s, input [7:0] fc);
        reg [31:0] q;
        integer n;
        slow <= s;
        wr(8'h00, 32'h0000_0001);
        n = 0;
        while (cfg_wr !== 1'b0 && n < 100) begin
            n = n + 1;
            @(posedge ref_clk_i);
        end
        check(n < 100, 1'b1);
        for (n = 0; n < 14; n = n + 1)
            check(u_dev.regs[n], (n == 11) ? {24'h0, fc} : CFG_EXP[n*32 +: 32]);
        check({31'h0, u_dev.order_err}, 32'h0000_0000);
        wb_cycle(8'h04, 1'b0, 32'h0, q);
        check({31'h0, q[0]}, 32'h0000_0001);
        $display("test config done");
    endtask
    // full job; optionally a second start while busy, which must be ignored
    task automatic t_job(input [31:0] tx, input [31:0] dw, input [7:0] fc, input twice);
        reg [31:0] q;
        dev_word <= dw;
        wr(8'h08, tx);
        wb_cycle(8'h08, 1'b0, 32'h0, q);
        check(q, tx);
        wr(8'h00, 32'h0000_0002);
        // start and config both refused while the link is busy
        if (twice) wr(8'h00, 32'h0000_0003);
        check({31'h0, cfg_wr}, 32'h0000_0000);
        wait_done;
        check(u_dev.rx_word, tx);
        check({24'h0, u_dev.frames}, {24'h0, fc});
        check({31'h0, u_dev.active}, 32'h0000_0000);
        wb_cycle(8'h04, 1'b0, 32'h0, q);
        check(q, {20'h0, fc, 4'hD});
        wb_cycle(8'h0C, 1'b0, 32'h0, q);
        check(q, dw);
        wb_cycle(8'h04, 1'b0, 32'h0, q);
        check({31'h0, q[2]}, 32'h0000_0000);
        $display("test job done");
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_idle;
        t_config(1'b1, 8'h04);
        t_job(32'hA5C3_0F81, 32'h5A3C_F018, 8'h04, 1'b0);
        wr(8'h10, 32'h0000_0001);
        t_config(1'b0, 8'h01);
        t_job(32'h8000_0001, 32'h0000_FFFE, 8'h01, 1'b1);
        end_of_test;
    end
endmodule // tb
